// File: rtl/tei_defines.svh
// constants for the trace event input resources block
`ifndef TEI_DEFINES_SVH
`define TEI_DEFINES_SVH

// ---------------------------------------------------------------------
// implemented resource counts
// ---------------------------------------------------------------------
`define TEI_NUM_INSTR        3'h4
`define TEI_NUM_EXT_IN       3'h4
`define TEI_NUM_SEL          3'h4
`define TEI_XBUS_W           8'h08
`define TEI_HAS_SECURITY     1'b1

// ---------------------------------------------------------------------
// configuration field positions
// ---------------------------------------------------------------------
`define TEI_CCER_INSTR_HI    15
`define TEI_CCER_INSTR_LO    13
`define TEI_CCER_XBUS_HI     10
`define TEI_CCER_XBUS_LO     3
`define TEI_CCER_SEL_HI      2
`define TEI_CCER_SEL_LO      0
`define TEI_CCR_EXTERNAL_EVENT_INPUT_HI     19
`define TEI_CCR_EXTERNAL_EVENT_INPUT_LO     17
`define TEI_SEL_FIELD_W      8

// ---------------------------------------------------------------------
// hint decode and resource selection encoding
// ---------------------------------------------------------------------
`define TEI_HINT_GRP_SET     2'h0
`define TEI_HINT_GRP_CLR     2'h1
`define TEI_HINT_GRP_PULSE   2'h2
`define TEI_HINT_LAST        4'hb
`define TEI_RES_TYPE_INSTR   7'h11
`define TEI_RES_IDX_FIRST    4'h8
`define TEI_RES_IDX_LAST     4'hb

`endif

// File: rtl/tei_pkg.sv
// types for the trace event input resources block
package tei_pkg;

  // -------------------------------------------------------------------
  // state of the top module
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  instr_ff;
    logic [3:0]  instr_res_ff;
    logic [3:0]  ext_meta_ff;
    logic [3:0]  ext_sync_ff;
    logic [3:0]  ext_res_ff;
    logic        ns_res_ff;
    logic        prohib_res_ff;
    logic        true_res_ff;
    logic        seen_wp_ff;
    logic        res_sel_ff;
    logic [31:0] ccer_ff;
    logic [31:0] ccr_ff;
  } tei_main_state_type;

  // -------------------------------------------------------------------
  // state of the extended input selectors
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] bus_meta_ff;
    logic [7:0] bus_sync_ff;
    logic [3:0] sel_res_ff;
  } tei_sel_state_type;

endpackage

// File: rtl/tei_ext_sel.sv
// extended external input selectors
`timescale 1ns/1ps
`include "tei_defines.svh"

module tei_ext_sel (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  ext_bus,
  input  wire logic [31:0] ext_input_select_reg,
  output logic      [3:0]  sel_res
);
  import tei_pkg::*;

  tei_sel_state_type st_ff;
  tei_sel_state_type nxt_st;
  logic [3:0]        pick;

  // -------------------------------------------------------------------
  // one selector per field; out of range index reads low
  // -------------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_sel
    logic [7:0] idx;
    assign idx = ext_input_select_reg[g*`TEI_SEL_FIELD_W +: 8];
    assign pick[g] = (idx < `TEI_XBUS_W) ?
                     st_ff.bus_sync_ff[idx[2:0]] : 1'b0; // [RULE12]
  end

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.bus_meta_ff = ext_bus;
    nxt_st.bus_sync_ff = st_ff.bus_meta_ff;
    nxt_st.sel_res_ff  = pick; // [RULE12]
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sel_res = st_ff.sel_res_ff;

endmodule

// File: rtl/tei_event_inputs.sv
// trace event input resources: instrumentation, inputs, state flags
`timescale 1ns/1ps
`include "tei_defines.svh"

// Summary of operation
// [RULE1] up to four instrumentation resources; count in ext config 15:13
// [RULE2] set makes resource active now and until cleared
// [RULE3] clear makes resource inactive now and until set or pulsed
// [RULE4] pulse is active in execution cycle only, even if already set
// [RULE5] privileged-only bit blocks hint effects outside privileged mode
// [RULE6] instrumentation resources selected by type 0x11, index 8 to 11
// [RULE7] hint 0-3 set, 4-7 clear, 8-b pulse resources 1 to 4
// [RULE8] hint values above 0xb change nothing
// [RULE9] parallel hints act in program order; any activation shows this cycle
// [RULE10] group set stays until later clear; next clear limits to one cycle
// [RULE11] four external inputs, count shown in config 19:17
// [RULE12] selectors drive resources from chosen bus bit
// [RULE13] ext config shows bus width in 10:3, selector count in 2:0
// [RULE14] non-secure resource true while core runs non-secure
// [RULE15] non-secure resource false until first waypoint traced
// [RULE16] trace-prohibited resource true while tracing prohibited
// [RULE17] trace-prohibited resource true until first waypoint traced
// [RULE18] constant true resource always present
// [RULE19] external inputs give imprecise trace control for software
module tei_event_inputs (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        hint_vld_0,
  input  wire logic [3:0]  hint_val_0,
  input  wire logic        hint_vld_1,
  input  wire logic [3:0]  hint_val_1,
  input  wire logic        core_priv,
  input  wire logic        instr_priv_only,
  input  wire logic        core_nonsecure,
  input  wire logic        trace_prohibited,
  input  wire logic        trace_enabled,
  input  wire logic        waypoint_traced,
  input  wire logic [3:0]  external_event_input,
  input  wire logic [7:0]  ext_bus,
  input  wire logic [31:0] ext_input_select_reg,
  input  wire logic [6:0]  res_sel_type,
  input  wire logic [3:0]  res_sel_index,
  output logic      [3:0]  instr_res,
  output logic      [3:0]  ext_in_res,
  output logic      [3:0]  ext_sel_res,
  output logic             nonsecure_res,
  output logic             prohibited_res,
  output logic             true_res,
  output logic             res_sel_active,
  output logic      [31:0] config_code_ext_reg,
  output logic      [31:0] config_code_reg
);
  import tei_pkg::*;

  tei_main_state_type st_ff;
  tei_main_state_type nxt_st;
  logic               hint_ok;
  logic [3:0]         held;

  // -------------------------------------------------------------------
  // hint gating
  // -------------------------------------------------------------------
  // with no resources built the control bit has nothing to guard
  assign hint_ok = (`TEI_NUM_INSTR == 3'h0) ||
                   !instr_priv_only || core_priv; // [RULE5]
  assign held    = st_ff.instr_ff;

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    logic [3:0] seq;
    logic [3:0] act;
    logic [1:0] vld;
    logic [3:0] hv [2];
    seq    = st_ff.instr_ff;
    act    = 4'h0;
    vld    = {hint_vld_1, hint_vld_0};
    hv[0]  = hint_val_0;
    hv[1]  = hint_val_1;
    nxt_st = st_ff;
    // slot 0 is older in program order, so it is applied first
    for (int s = 0; s < 2; s++) begin // [RULE9]
      if (vld[s] && hint_ok && hv[s] <= `TEI_HINT_LAST) begin // [RULE8]
        unique case (hv[s][3:2]) // [RULE7]
          `TEI_HINT_GRP_SET: begin
            seq[hv[s][1:0]] = 1'b1; // [RULE2]
            act[hv[s][1:0]] = 1'b1;
          end
          `TEI_HINT_GRP_CLR: begin
            seq[hv[s][1:0]] = 1'b0; // [RULE3]
          end
          default: begin
            seq[hv[s][1:0]] = 1'b0; // [RULE4]
            act[hv[s][1:0]] = 1'b1;
          end
        endcase
      end
    end
    nxt_st.instr_ff     = seq; // [RULE10]
    nxt_st.instr_res_ff = seq | act; // [RULE9]

    nxt_st.ext_meta_ff = external_event_input;
    nxt_st.ext_sync_ff = st_ff.ext_meta_ff;
    // inputs are not tied to memory accesses, so they are imprecise
    nxt_st.ext_res_ff  = st_ff.ext_sync_ff; // [RULE11] [RULE19]

    if (waypoint_traced) begin
      nxt_st.seen_wp_ff = 1'b1;
    end
    if (trace_enabled && !st_ff.seen_wp_ff) begin
      nxt_st.ns_res_ff     = 1'b0; // [RULE15]
      nxt_st.prohib_res_ff = 1'b1; // [RULE17]
    end else begin
      nxt_st.ns_res_ff     = `TEI_HAS_SECURITY & core_nonsecure; // [RULE14]
      nxt_st.prohib_res_ff = trace_prohibited; // [RULE16]
    end
    nxt_st.true_res_ff = 1'b1; // [RULE18]

    nxt_st.res_sel_ff = (res_sel_type == `TEI_RES_TYPE_INSTR) &&
                        (res_sel_index >= `TEI_RES_IDX_FIRST) &&
                        (res_sel_index <= `TEI_RES_IDX_LAST) &&
                        st_ff.instr_res_ff[res_sel_index[1:0]]; // [RULE6]

    nxt_st.ccer_ff = 32'h0;
    nxt_st.ccer_ff[`TEI_CCER_INSTR_HI:`TEI_CCER_INSTR_LO] =
      `TEI_NUM_INSTR; // [RULE1]
    nxt_st.ccer_ff[`TEI_CCER_XBUS_HI:`TEI_CCER_XBUS_LO] =
      `TEI_XBUS_W; // [RULE13]
    nxt_st.ccer_ff[`TEI_CCER_SEL_HI:`TEI_CCER_SEL_LO] =
      `TEI_NUM_SEL; // [RULE13]
    nxt_st.ccr_ff = 32'h0;
    nxt_st.ccr_ff[`TEI_CCR_EXTERNAL_EVENT_INPUT_HI:`TEI_CCR_EXTERNAL_EVENT_INPUT_LO] =
      `TEI_NUM_EXT_IN; // [RULE11]
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_ff               <= '0;
      st_ff.prohib_res_ff <= 1'b1;
      st_ff.true_res_ff   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // -------------------------------------------------------------------
  // extended input selectors
  // -------------------------------------------------------------------
  tei_ext_sel u_sel (
    .ref_clk              (ref_clk),
    .srst                 (srst),
    .ext_bus              (ext_bus),
    .ext_input_select_reg (ext_input_select_reg),
    .sel_res              (ext_sel_res)
  );

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign instr_res           = st_ff.instr_res_ff;
  assign ext_in_res          = st_ff.ext_res_ff;
  assign nonsecure_res       = st_ff.ns_res_ff;
  assign prohibited_res      = st_ff.prohib_res_ff;
  assign true_res            = st_ff.true_res_ff;
  assign res_sel_active      = st_ff.res_sel_ff;
  assign config_code_ext_reg = st_ff.ccer_ff;
  assign config_code_reg     = st_ff.ccr_ff;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic touch0;
  logic quiet;
  assign touch0 = hint_ok &&
    ((hint_vld_0 && hint_val_0 <= 4'hb && hint_val_0[1:0] == 2'h0) ||
     (hint_vld_1 && hint_val_1 <= 4'hb && hint_val_1[1:0] == 2'h0));
  assign quiet  = (!hint_vld_0 || hint_val_0 > 4'hb) &&
                  (!hint_vld_1 || hint_val_1 > 4'hb);

  sequence s_set0;
    hint_ok && hint_vld_0 && hint_val_0 == 4'h0 && !hint_vld_1;
  endsequence
  sequence s_clr0;
    hint_ok && hint_vld_0 && hint_val_0 == 4'h4 && !hint_vld_1;
  endsequence
  sequence s_pul0;
    hint_ok && hint_vld_0 && hint_val_0 == 4'h8 && !hint_vld_1;
  endsequence
  sequence s_grp_clr_set0;
    hint_ok && hint_vld_0 && hint_val_0 == 4'h4 &&
    hint_vld_1 && hint_val_1 == 4'h0;
  endsequence
  sequence s_grp_pul_clr0;
    hint_ok && hint_vld_0 && hint_val_0 == 4'h8 &&
    hint_vld_1 && hint_val_1 == 4'h4;
  endsequence

  property p_set_holds;
    s_set0 ##1 !touch0 |=> instr_res[0] && held[0];
  endproperty
  a_set_holds: assert property (p_set_holds) // [RULE2]
    else $error("set did not hold resource active");

  property p_clr_drops;
    s_clr0 |=> !instr_res[0] && !held[0];
  endproperty
  a_clr_drops: assert property (p_clr_drops) // [RULE3]
    else $error("clear did not drop resource");

  property p_pulse_one;
    s_pul0 ##1 !touch0 |-> instr_res[0] ##1 !instr_res[0];
  endproperty
  a_pulse_one: assert property (p_pulse_one) // [RULE4]
    else $error("pulse not exactly one cycle");

  property p_priv_block;
    instr_priv_only && !core_priv |=> instr_res == $past(held);
  endproperty
  a_priv_block: assert property (p_priv_block) // [RULE5]
    else $error("hint acted outside privileged mode");

  property p_high_hint_nop;
    quiet |=> instr_res == $past(held) && $stable(held);
  endproperty
  a_high_hint_nop: assert property (p_high_hint_nop) // [RULE8]
    else $error("unused hint changed a resource");

  property p_par_activate;
    s_grp_pul_clr0 |=> instr_res[0] ##1 !instr_res[0] || $past(touch0);
  endproperty
  a_par_activate: assert property (p_par_activate) // [RULE9]
    else $error("parallel activation lost");

  property p_grp_then_clr;
    s_grp_clr_set0 ##1 s_clr0 |-> instr_res[0] ##1 !instr_res[0];
  endproperty
  a_grp_then_clr: assert property (p_grp_then_clr) // [RULE10]
    else $error("group set not cut by next clear");

  property p_ns_before_wp;
    trace_enabled && !st_ff.seen_wp_ff |=> !nonsecure_res;
  endproperty
  a_ns_before_wp: assert property (p_ns_before_wp) // [RULE15]
    else $error("non-secure true before first waypoint");

  property p_prohib_before_wp;
    trace_enabled && !st_ff.seen_wp_ff |=> prohibited_res;
  endproperty
  a_prohib_before_wp: assert property (p_prohib_before_wp) // [RULE17]
    else $error("prohibited false before first waypoint");

  property p_prohib_follow;
    st_ff.seen_wp_ff |=> prohibited_res == $past(trace_prohibited);
  endproperty
  a_prohib_follow: assert property (p_prohib_follow) // [RULE16]
    else $error("prohibited does not follow input");

  property p_true_const;
    ##1 1'b1 |-> true_res;
  endproperty
  a_true_const: assert property (p_true_const) // [RULE18]
    else $error("constant resource dropped");

  property p_config_fields;
    !$past(srst) |-> config_code_ext_reg[15:13] == 3'h4 &&
      config_code_ext_reg[10:3] == 8'h08 &&
      config_code_ext_reg[2:0] == 3'h4 &&
      config_code_reg[19:17] == 3'h4;
  endproperty
  a_config_fields: assert property (p_config_fields) // [RULE13]
    else $error("configuration field wrong");

  property p_ext_lat;
    ##3 1'b1 |-> ext_in_res == $past(external_event_input, 3);
  endproperty
  a_ext_lat: assert property (p_ext_lat) // [RULE11]
    else $error("external input latency wrong");

  property p_ns_follow;
    st_ff.seen_wp_ff |=> nonsecure_res == $past(core_nonsecure);
  endproperty
  a_ns_follow: assert property (p_ns_follow) // [RULE14]
    else $error("non-secure does not follow core state");

  property p_sel_instr;
    res_sel_type == 7'h11 && res_sel_index == 4'h9 |=>
      res_sel_active == $past(instr_res[1]);
  endproperty
  a_sel_instr: assert property (p_sel_instr) // [RULE6]
    else $error("instrumentation resource 2 not selected");

  property p_sel_other;
    res_sel_type != 7'h11 |=> !res_sel_active;
  endproperty
  a_sel_other: assert property (p_sel_other) // [RULE6]
    else $error("other resource type selected instrumentation");

  property p_pulse_last;
    hint_ok && hint_vld_0 && hint_val_0 == 4'hb |=> instr_res[3];
  endproperty
  a_pulse_last: assert property (p_pulse_last) // [RULE7]
    else $error("pulse of resource 4 not shown");

endmodule

// File: sim/tei_core_model.sv
// behavioural core issuing debug hint instructions in two slots
`timescale 1ns/1ps
module tei_core_model (
  input  wire logic       ref_clk,
  output logic            hint_vld_0,
  output logic      [3:0] hint_val_0,
  output logic            hint_vld_1,
  output logic      [3:0] hint_val_1,
  output logic            core_priv,
  output logic            core_nonsecure
);
  initial begin
    hint_vld_0     = 1'b0;
    hint_val_0     = 4'h0;
    hint_vld_1     = 1'b0;
    hint_val_1     = 4'h0;
    core_priv      = 1'b0;
    core_nonsecure = 1'b0;
  end

  // one issue group per edge; slot 0 is older in program order
  // an idle group must be issued too, or the last hints would repeat
  task automatic issue(input logic v0, input logic [3:0] a,
                       input logic v1, input logic [3:0] b,
                       input logic pv, input logic ns);
    @(posedge ref_clk);
    hint_vld_0     <= v0;
    hint_val_0     <= v0 ? a : ~hint_val_0;
    hint_vld_1     <= v1;
    hint_val_1     <= v1 ? b : ~hint_val_1;
    core_priv      <= pv;
    core_nonsecure <= ns;
  endtask
endmodule

// File: sim/tei_event_inputs_bench.sv
// self-checking bench for the trace event input resources block
`timescale 1ns/1ps
module tei_event_inputs_bench;
  import tei_pkg::*;
  typedef struct {
    int          due;
    int          id;
    logic [31:0] v;
  } tei_note_type;

  logic ref_clk = 1'b0, srst = 1'b1, instr_priv_only = 1'b0;
  logic trace_prohibited = 1'b0, trace_enabled = 1'b1;
  logic waypoint_traced = 1'b0, hint_vld_0, hint_vld_1;
  logic core_priv, core_nonsecure, nonsecure_res, prohibited_res;
  logic true_res, res_sel_active;
  logic [3:0]  hint_val_0, hint_val_1, instr_res, ext_in_res, ext_sel_res;
  logic [3:0]  external_event_input = 4'h0, res_sel_index = 4'h0;
  logic [7:0]  ext_bus = 8'h00;
  logic [6:0]  res_sel_type = 7'h00, rtype = 7'h00;
  logic [31:0] ext_input_select_reg = 32'h0, config_code_ext_reg;
  logic [31:0] config_code_reg, selr = 32'h0, r;
  logic [3:0]  st = 4'h0, pins = 4'h0, ridx = 4'h0;
  logic [7:0]  bus = 8'h00;
  logic        priv = 1'b0, nsec = 1'b0, pr_only = 1'b0;
  logic        prohib = 1'b0, wp = 1'b0;
  int          cyc = 0, seed = 78844, n_errors = 0, check_count = 0;
  tei_note_type notes[$];

  tei_event_inputs dut (.ref_clk, .srst, .hint_vld_0, .hint_val_0,
    .hint_vld_1, .hint_val_1, .core_priv, .instr_priv_only,
    .core_nonsecure, .trace_prohibited, .trace_enabled, .waypoint_traced,
    .external_event_input, .ext_bus, .ext_input_select_reg, .res_sel_type,
    .res_sel_index, .instr_res, .ext_in_res, .ext_sel_res, .nonsecure_res,
    .prohibited_res, .true_res, .res_sel_active, .config_code_ext_reg,
    .config_code_reg);
  tei_core_model core (.ref_clk, .hint_vld_0, .hint_val_0, .hint_vld_1,
    .hint_val_1, .core_priv, .core_nonsecure);

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic push(input int id, input logic [31:0] v, input int lat);
    notes.push_back('{cyc + lat, id, v});
  endtask

  task automatic apply(input logic v, input logic [3:0] h,
                       inout logic [3:0] act);
    if (v && !(pr_only && !priv) && h <= 4'hb) begin
      case (h[3:2])
        2'h0: begin st[h[1:0]] = 1'b1; act[h[1:0]] = 1'b1; end
        2'h1: st[h[1:0]] = 1'b0;
        default: begin st[h[1:0]] = 1'b0; act[h[1:0]] = 1'b1; end
      endcase
    end
  endtask

  task automatic step(input logic v0, input logic [3:0] a,
                      input logic v1, input logic [3:0] b);
    logic [3:0] act;
    act = 4'h0;
    core.issue(v0, a, v1, b, priv, nsec);
    instr_priv_only      <= pr_only;
    trace_prohibited     <= prohib;
    waypoint_traced      <= wp;
    external_event_input <= pins;
    ext_bus              <= bus;
    ext_input_select_reg <= selr;
    res_sel_type         <= rtype;
    res_sel_index        <= ridx;
    apply(v0, a, act);
    apply(v1, b, act);
    push(0, {28'h0, st | act}, 2);
  endtask

  function automatic logic [3:0] selx(input logic [7:0] b);
    logic [7:0] idx;
    for (int n = 0; n < 4; n++) begin
      idx = selr[8*n +: 8];
      selx[n] = (idx < 8'h08) ? b[idx[2:0]] : 1'b0;
    end
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // monitor: retire every note whose cycle has come
  // ---------------------------------------------------------------
  always @(negedge ref_clk) begin
    tei_note_type nt;
    int           i;
    i = 0;
    while (i < notes.size()) begin
      nt = notes[i];
      if (nt.due > cyc) i++;
      else begin
        notes.delete(i);
        case (nt.id)
          0: check("instr_res", {28'h0, instr_res}, nt.v);
          1: check("ext_in_res", {28'h0, ext_in_res}, nt.v);
          2: check("ext_sel_res", {28'h0, ext_sel_res}, nt.v);
          3: check("nonsecure_res", {31'h0, nonsecure_res}, nt.v);
          4: check("prohibited_res", {31'h0, prohibited_res},
                   nt.v);
          5: check("res_sel_active", {31'h0, res_sel_active},
                   nt.v);
          6: check("true_res", {31'h0, true_res}, nt.v);
          7: check("config_code_ext_reg", config_code_ext_reg,
                   nt.v);
          default: check("config_code_reg", config_code_reg,
                         nt.v);
        endcase
      end
    end
  end

  // watchdog: the whole sequence needs well under 600 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    $display("timeout waiting for the sequence");
    close_out();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] pairs [7];
    pairs = '{8'h40, 8'h48, 8'hf8, 8'hf0, 8'h04, 8'hf4, 8'h84};
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    step(1'b0, 4'h0, 1'b0, 4'h0);
    push(7, 32'h0000_8044, 2);
    push(8, 32'h0008_0000, 2);
    push(6, 32'h1, 2);
    // with the unit disabled the flags follow the core at once
    nsec = 1'b1;
    trace_enabled <= 1'b0;
    step(1'b0, 4'h0, 1'b0, 4'h0);
    push(3, 32'h1, 2);
    push(4, 32'h0, 2);
    step(1'b0, 4'h0, 1'b0, 4'h0);
    trace_enabled <= 1'b1;
    // before any waypoint the state flags are forced
    repeat (3) step(1'b0, 4'h0, 1'b0, 4'h0);
    push(3, 32'h0, 2);
    push(4, 32'h1, 2);
    wp = 1'b1;
    step(1'b0, 4'h0, 1'b0, 4'h0);
    wp = 1'b0;
    repeat (3) step(1'b0, 4'h0, 1'b0, 4'h0);
    for (int k = 0; k < 4; k++) begin
      nsec = k[0];
      prohib = k[1];
      step(1'b0, 4'h0, 1'b0, 4'h0);
      push(3, {31'h0, nsec}, 2);
      push(4, {31'h0, prohib}, 2);
    end
    $display("test state resources done");
    for (int k = 0; k < 16; k++) step(1'b1, k[3:0], 1'b0, 4'h0);
    step(1'b1, 4'h0, 1'b0, 4'h0);
    step(1'b0, 4'h0, 1'b1, 4'h8);
    step(1'b0, 4'h0, 1'b0, 4'h0);
    $display("test hint codes done");
    foreach (pairs[k]) begin
      step(1'b1, pairs[k][7:4], 1'b1, pairs[k][3:0]);
      step(1'b0, 4'h0, 1'b0, 4'h0);
    end
    step(1'b1, 4'h4, 1'b1, 4'h0);
    step(1'b1, 4'h4, 1'b0, 4'h0);
    step(1'b1, 4'h0, 1'b1, 4'h1);
    step(1'b1, 4'h4, 1'b0, 4'h0);
    step(1'b0, 4'h0, 1'b0, 4'h0);
    $display("test parallel groups done");
    pr_only = 1'b1;
    step(1'b1, 4'h2, 1'b1, 4'h5);
    priv = 1'b1;
    step(1'b1, 4'h2, 1'b0, 4'h0);
    pr_only = 1'b0;
    priv = 1'b0;
    step(1'b1, 4'h6, 1'b1, 4'h3);
    step(1'b0, 4'h0, 1'b0, 4'h0);
    $display("test privilege gating done");
    for (int k = 0; k < 17; k++) begin
      rtype = (k == 16) ? 7'h10 : 7'h11;
      ridx = (k == 16) ? 4'h8 : k[3:0];
      step(1'b0, 4'h0, 1'b0, 4'h0);
      push(5, {31'h0, (rtype == 7'h11 && ridx[3:2] == 2'h2) ?
                st[ridx[1:0]] : 1'b0}, 2);
    end
    $display("test resource select done");
    selr = 32'h0702_0905;
    repeat (2) step(1'b0, 4'h0, 1'b0, 4'h0);
    for (int k = 0; k < 300; k++) begin
      r = $random(seed);
      pins = r[13:10];
      bus = r[31:24];
      priv = r[20];
      pr_only = r[21];
      step(r[0], r[4:1], r[5], r[9:6]);
      push(1, {28'h0, pins}, 4);
      push(2, {28'h0, selx(bus)}, 4);
    end
    repeat (6) step(1'b0, 4'h0, 1'b0, 4'h0);
    $display("test random traffic done");
    close_out();
  end
endmodule
